// ==== hw/i2css_pkg.sv ====
// Package for the two-wire slave front end with soft reset call.
// Assumes one 200 MHz core clock; bus lines are sampled, never used as clocks.
`default_nettype none
package i2css_pkg;
  // ---------------------------------------------------------------
  // Reset call format
  // ---------------------------------------------------------------
  localparam logic [7:0] I2CSS_RST_ADDR_BYTE = 8'h06;
  localparam logic [6:0] I2CSS_RST_ADDR      = 7'h03;
  localparam logic [7:0] I2CSS_SIG_BYTE1     = 8'hA5;
  localparam logic [7:0] I2CSS_SIG_BYTE2     = 8'h5A;
  localparam logic [3:0] I2CSS_BYTE_BITS     = 4'h8;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int I2CSS_CLK_PS        = 5000;
  localparam int I2CSS_BUS_FREE_NS   = 500;
  // Longest time, rounded down, at least one cycle
  localparam int I2CSS_BUS_FREE_CYC  =
    (I2CSS_BUS_FREE_NS * 1000 / I2CSS_CLK_PS) < 1 ? 1 :
    (I2CSS_BUS_FREE_NS * 1000 / I2CSS_CLK_PS);
  // Cycles from the sampled STOP to the soft reset pulse
  localparam int I2CSS_SOFT_RST_CYC  = 1;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK, ST_IGNORE
  } i2css_state_t;

  typedef enum logic [1:0] {
    SR_NONE, SR_ADDR_OK, SR_SIG1_OK, SR_ARMED
  } i2css_rst_t;

  typedef struct packed {
    logic       first;
    logic [7:0] data;
  } i2css_wbyte_t;
endpackage : i2css_pkg
`default_nettype wire

// ==== hw/i2css_slave.sv ====
// Two-wire bus slave front end with own-address write/read path and the
// software reset call recogniser.
// Assumes clock and data pins arrive asynchronously and are oversampled;
// the bus clock must stay well below a quarter of the core clock.
`default_nettype none
module i2css_slave
  import i2css_pkg::*;
#(
  parameter logic [6:0] OWN_ADDR = 7'h20
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         scl_i,
  input  wire logic         sda_i,
  output logic              sda_o,
  output logic              sda_oe,
  output i2css_wbyte_t      wr_byte,
  output logic              wr_valid,
  input  wire logic [7:0]   rd_data,
  output logic              rd_take,
  output logic              soft_reset
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (OWN_ADDR == I2CSS_RST_ADDR) begin : g_bad_addr
    $error("Own address collides with the reset call address");
  end
  if (I2CSS_SOFT_RST_CYC > I2CSS_BUS_FREE_CYC) begin : g_bad_time
    $error("Soft reset slower than bus free time");
  end

  // ---------------------------------------------------------------
  // Pin synchronisers and condition detection
  // ---------------------------------------------------------------
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic       scl_p_q;
  logic       sda_p_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_p_q    <= 1'b1;
      sda_p_q    <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], scl_i};
      sda_sync_q <= {sda_sync_q[0], sda_i};
      scl_p_q    <= scl_sync_q[1];
      sda_p_q    <= sda_sync_q[1];
    end
  end

  wire scl_s    = scl_sync_q[1];
  wire sda_s    = sda_sync_q[1];
  wire scl_rise = scl_s & ~scl_p_q;
  wire scl_fall = ~scl_s & scl_p_q;
  wire start_c  = scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire stop_c   = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // ---------------------------------------------------------------
  // Byte engine state
  // ---------------------------------------------------------------
  i2css_state_t st_q;
  i2css_state_t st_d;
  i2css_rst_t   sr_q;
  i2css_rst_t   sr_d;
  logic [3:0]   cnt_q;
  logic [3:0]   cnt_d;
  logic [7:0]   sh_q;
  logic [7:0]   sh_d;
  logic         first_q;
  logic         rd_q;
  logic         dfirst_q;
  logic         ack_q;
  logic         mack_q;
  logic         oe_q;
  logic         oe_d;

  // ---------------------------------------------------------------
  // Acknowledge decision at end of a received byte
  // ---------------------------------------------------------------
  wire byte_end  = (st_q == ST_RX) & scl_fall & (cnt_q == I2CSS_BYTE_BITS);
  wire hit_own   = (sh_q[7:1] == OWN_ADDR);
  // Reserved address compared independently of OWN_ADDR
  wire hit_rst   = (sh_q == I2CSS_RST_ADDR_BYTE);
  wire addr_ack  = hit_rst | (hit_own & ~(sh_q[7:1] == I2CSS_RST_ADDR));
  wire sig1_ok   = (sh_q == I2CSS_SIG_BYTE1);
  wire sig2_ok   = (sh_q == I2CSS_SIG_BYTE2);
  wire in_call   = (sr_q != SR_NONE);

  logic data_ack;
  always_comb begin
    data_ack = 1'b1;
    case (sr_q)
      SR_ADDR_OK: data_ack = sig1_ok;
      SR_SIG1_OK: data_ack = sig2_ok;
      SR_ARMED:   data_ack = 1'b0;
      default:    data_ack = 1'b1;
    endcase
  end

  wire byte_ack = first_q ? addr_ack : data_ack;

  // Reset call progress; any slip drops back to none
  always_comb begin
    sr_d = sr_q;
    if (start_c || stop_c) begin
      sr_d = SR_NONE;
    end else if (byte_end && first_q) begin
      sr_d = hit_rst ? SR_ADDR_OK : SR_NONE;
    end else if (byte_end && in_call) begin
      case (sr_q)
        SR_ADDR_OK: sr_d = sig1_ok ? SR_SIG1_OK : SR_NONE;
        SR_SIG1_OK: sr_d = sig2_ok ? SR_ARMED : SR_NONE;
        default:    sr_d = SR_NONE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Bit sequencing; data line drive changes only on clock fall, START or STOP
  // ---------------------------------------------------------------
  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    sh_d  = sh_q;
    oe_d  = oe_q;
    if (start_c) begin
      st_d  = ST_RX;
      cnt_d = 4'h0;
      oe_d  = 1'b0;
    end else if (stop_c) begin
      st_d  = ST_IDLE;
      oe_d  = 1'b0;
    end else begin
      case (st_q)
        ST_RX: begin
          if (scl_rise) begin
            sh_d  = {sh_q[6:0], sda_s};
            cnt_d = cnt_q + 4'h1;
          end else if (byte_end) begin
            st_d  = ST_ACK;
            oe_d  = byte_ack;
            cnt_d = 4'h0;
          end
        end
        ST_ACK: begin
          // Held low across the whole acknowledge clock high phase
          if (scl_fall) begin
            if (!ack_q) begin
              st_d = ST_IGNORE;
              oe_d = 1'b0;
            end else if (rd_q) begin
              st_d = ST_TX;
              sh_d = rd_data;
              oe_d = ~rd_data[7];
            end else begin
              st_d = ST_RX;
              oe_d = 1'b0;
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall) begin
            if (cnt_q == I2CSS_BYTE_BITS) begin
              st_d  = ST_MACK;
              oe_d  = 1'b0;
              cnt_d = 4'h0;
            end else begin
              sh_d = {sh_q[6:0], 1'b0};
              oe_d = ~sh_q[6];
            end
          end
        end
        ST_MACK: begin
          if (scl_fall) begin
            if (mack_q) begin
              st_d = ST_TX;
              sh_d = rd_data;
              oe_d = ~rd_data[7];
            end else begin
              st_d = ST_IGNORE;
              oe_d = 1'b0;
            end
          end
        end
        ST_IDLE, ST_IGNORE: oe_d = 1'b0;
        default: begin
          st_d = ST_IDLE;
          oe_d = 1'b0;
        end
      endcase
    end
  end

  wire load_tx  = scl_fall & (((st_q == ST_ACK) & ack_q & rd_q) |
                              ((st_q == ST_MACK) & mack_q));
  wire own_wr   = byte_end & ~first_q & ~in_call;
  wire do_reset = stop_c & (sr_q == SR_ARMED);

  // ---------------------------------------------------------------
  // Registers; soft reset returns the byte engine registers to power-up values, wr_byte keeps its value
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q    <= ST_IDLE;
      sr_q    <= SR_NONE;
      cnt_q   <= 4'h0;
      sh_q    <= 8'h00;
      first_q <= 1'b0;
      rd_q    <= 1'b0;
      dfirst_q <= 1'b0;
      ack_q   <= 1'b0;
      mack_q  <= 1'b0;
      oe_q    <= 1'b0;
    end else if (do_reset) begin
      st_q    <= ST_IDLE;
      sr_q    <= SR_NONE;
      cnt_q   <= 4'h0;
      sh_q    <= 8'h00;
      first_q <= 1'b0;
      rd_q    <= 1'b0;
      dfirst_q <= 1'b0;
      ack_q   <= 1'b0;
      mack_q  <= 1'b0;
      oe_q    <= 1'b0;
    end else begin
      st_q    <= st_d;
      sr_q    <= sr_d;
      cnt_q   <= cnt_d;
      sh_q    <= sh_d;
      oe_q    <= oe_d;
      if (start_c) begin
        first_q <= 1'b1;
      end else if (byte_end) begin
        first_q <= 1'b0;
      end
      if (byte_end) begin
        ack_q <= byte_ack;
      end
      if (byte_end && first_q) begin
        rd_q <= sh_q[0];
      end
      // Marks the first data byte after the address
      if (byte_end && first_q) begin
        dfirst_q <= 1'b1;
      end else if (own_wr) begin
        dfirst_q <= 1'b0;
      end
      // Master drives low on its acknowledge
      if ((st_q == ST_MACK) && scl_rise) begin
        mack_q <= ~sda_s;
      end
    end
  end

  // Strobes and write data come from flops; own-address write only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_byte    <= '0;
      wr_valid   <= 1'b0;
      rd_take    <= 1'b0;
      soft_reset <= 1'b0;
    end else begin
      wr_valid   <= own_wr & ~do_reset;
      rd_take    <= load_tx & ~do_reset;
      soft_reset <= do_reset;
      if (own_wr) begin
        wr_byte <= '{first: dfirst_q, data: sh_q};
      end
    end
  end

  // Open-drain: only ever pulls low
  assign sda_o  = 1'b0;
  assign sda_oe = oe_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_ADDR_ACK: assert property (
    byte_end && first_q && sh_q == 8'h06 && !start_c && !stop_c
    |=> sda_oe ##0 st_q == ST_ACK)
    else $error("Reset address 06h not acknowledged");
  AST_ADDR_RD_NACK: assert property (
    byte_end && first_q && sh_q == 8'h07 |=> !sda_oe)
    else $error("Reset address with read bit acknowledged");
  AST_SIG1: assert property (
    byte_end && sr_q == SR_ADDR_OK && sh_q != 8'hA5 |=> !sda_oe)
    else $error("Wrong first signature acknowledged");
  AST_SIG2: assert property (
    byte_end && sr_q == SR_SIG1_OK && sh_q == 8'h5A
    |=> sda_oe && sr_q == SR_ARMED)
    else $error("Good second signature not acknowledged");
  AST_EXTRA_NACK: assert property (
    byte_end && sr_q == SR_ARMED |=> !sda_oe ##1 sr_q == SR_NONE)
    else $error("Byte after signature acknowledged");
  AST_STOP_RST: assert property (
    stop_c && sr_q == SR_ARMED |=> st_q == ST_IDLE && soft_reset)
    else $error("Armed reset call not carried out on STOP");
  AST_ONLY_ARMED: assert property (
    soft_reset |-> $past(stop_c && sr_q == SR_ARMED))
    else $error("Soft reset without a complete reset call");
  AST_ACK_HOLD: assert property (
    st_q == ST_ACK && ack_q && scl_s |-> sda_oe)
    else $error("Acknowledge not held through clock high");
  AST_TX_RELEASE: assert property (
    st_q == ST_MACK && scl_fall && !mack_q |=> !sda_oe[*3])
    else $error("Data line not released after master nack");
  AST_SDA_STABLE: assert property (
    $changed(sda_oe) |-> $past(scl_fall) || $past(start_c || stop_c))
    else $error("Data line changed outside clock low");
  AST_COND_CLR: assert property (
    start_c || stop_c |=> sr_q == SR_NONE && !sda_oe)
    else $error("START or STOP did not clear the recogniser");
  AST_BIT_COUNT: assert property (
    cnt_q <= 4'h8)
    else $error("Bit counter beyond one byte");

  COV_RESET_CALL: cover property (soft_reset);
  COV_OWN_WRITE:  cover property (wr_valid ##[1:400] wr_valid);
  COV_READ_NACK:  cover property (st_q == ST_MACK && scl_fall && !mack_q);
  COV_BAD_SIG:    cover property (byte_end && sr_q == SR_ADDR_OK && !sig1_ok);

endmodule : i2css_slave
`default_nettype wire

// ==== tb/i2css_master.sv ====
// Behavioural bus master that drives the slave's clock and data pins.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`default_nettype none
module i2css_master (
  input  wire logic clk,
  input  wire logic sda_line,
  output var  logic scl,
  output var  logic sda_m
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // Bit timing: a bit lasts ten core cycles, all moves on clk rise
  // ---------------------------------------------------------------
  initial begin
    scl   = 1'b1;
    sda_m = 1'b1;
  end

  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask : w

  task automatic start();
    sda_m <= 1'b1;
    scl   <= 1'b1;
    w(5);
    sda_m <= 1'b0;
    w(5);
    scl   <= 1'b0;
    w(3);
  endtask : start

  task automatic stop();
    sda_m <= 1'b0;
    w(2);
    scl   <= 1'b1;
    w(5);
    sda_m <= 1'b1;
    w(5);
  endtask : stop

  // Data moves only while the clock is low
  task automatic put_bit(input logic b);
    sda_m <= b;
    w(2);
    scl   <= 1'b1;
    w(5);
    scl   <= 1'b0;
    w(3);
  endtask : put_bit

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic a1;
    logic a2;
    for (int i = 7; i >= 0; i--) put_bit(b[i]);
    sda_m <= 1'b1;
    w(2);
    scl   <= 1'b1;
    w(2);
    a1 = sda_line;
    w(3);
    a2 = sda_line;
    scl   <= 1'b0;
    w(3);
    ack = ~a1 & ~a2;
  endtask : send_byte

  // Level sampled in the acknowledge slot tells whether data was released
  task automatic recv_byte(input logic mack, output logic [7:0] b,
                           output logic lvl);
    for (int i = 7; i >= 0; i--) begin
      sda_m <= 1'b1;
      w(2);
      scl   <= 1'b1;
      w(3);
      b[i] = sda_line;
      w(2);
      scl   <= 1'b0;
      w(3);
    end
    sda_m <= ~mack;
    w(2);
    scl   <= 1'b1;
    w(3);
    lvl = sda_line;
    w(2);
    scl   <= 1'b0;
    w(3);
  endtask : recv_byte
endmodule : i2css_master
`default_nettype wire

// ==== tb/i2c_slave_soft_reset_tb_top.sv ====
// Self-checking bench for the slave front end and its soft reset call.
// Assumes the master model i2css_master; own address left at 7'h20.
`default_nettype none
module i2c_slave_soft_reset_tb_top import i2css_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // Wiring and pulse monitors
  // ---------------------------------------------------------------
  logic         clk     = 1'b0;
  logic         rst_n   = 1'b0;
  logic [7:0]   rd_data = 8'hC3;
  logic         sda_oe, sda_o, rd_take, soft_reset, wr_valid, scl, sda_m;
  i2css_wbyte_t wr_byte;
  logic [7:0]   wr_last;
  int           fail_count, samples_checked, sr_cnt, wr_cnt, rt_cnt;
  wire          sda_line = sda_m & ~(sda_oe & ~sda_o);

  always #2.5 clk = ~clk;

  always @(posedge clk) begin
    if (soft_reset === 1'b1) sr_cnt++;
    if (wr_valid === 1'b1) begin
      wr_cnt++;
      wr_last = wr_byte.data;
    end
    if (rd_take === 1'b1) rd_data <= 8'h96;
    if (rd_take === 1'b1) rt_cnt++;
  end

  i2css_slave #(.OWN_ADDR(7'h20)) dut (
    .clk(clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe(sda_oe), .wr_byte(wr_byte),
    .wr_valid(wr_valid), .rd_data(rd_data), .rd_take(rd_take),
    .soft_reset(soft_reset));

  i2css_master m (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_m(sda_m));

  // ---------------------------------------------------------------
  // Checking and verdict
  // ---------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string msg);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t ns: %s", $time, msg);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_por();
    check({sda_oe, wr_valid, rd_take, soft_reset}, 8'h00, "outputs");
    check(wr_byte.data, 8'h00, "write byte after reset");
    $display("test power-on done");
  endtask : t_por

  // Good call, then an own write at once: must be addressable again
  task automatic t_good();
    logic a;
    int   s0;
    int   w0;
    s0 = sr_cnt;
    w0 = wr_cnt;
    m.start();
    m.send_byte(8'h06, a);
    check(a, 8'h01, "reset address ack");
    m.send_byte(8'hA5, a);
    check(a, 8'h01, "first signature ack");
    m.send_byte(8'h5A, a);
    check(a, 8'h01, "second signature ack");
    m.stop();
    m.start();
    m.send_byte(8'h40, a);
    check(a, 8'h01, "own address after reset call");
    m.send_byte(8'h3C, a);
    m.stop();
    check(8'(sr_cnt - s0), 8'h01, "soft reset pulses");
    check(wr_last, 8'h3C, "written byte");
    check(8'(wr_cnt - w0), 8'h01, "write strobes");
    check({7'h00, wr_byte.first}, 8'h01, "first data byte mark");
    $display("test good reset call done");
  endtask : t_good

  // Master gives up at the first refusal, so a broken call ends there
  task automatic bad_call(input logic [31:0] seq, input int n,
                          input logic [3:0] exp);
    logic a;
    int   s0;
    s0 = sr_cnt;
    m.start();
    for (int i = 0; i < n; i++) begin
      m.send_byte(seq[31-8*i -: 8], a);
      check(a, 8'(exp[3-i]), "ack of call byte");
      if (a !== 1'b1) break;
    end
    m.stop();
    repeat (10) @(posedge clk);
    check(8'(sr_cnt - s0), 8'h00, "reset on malformed call");
    $display("test malformed call %h done", seq);
  endtask : bad_call

  task automatic t_read();
    logic       a;
    logic       l;
    logic [7:0] b;
    int         t0;
    t0 = rt_cnt;
    m.start();
    m.send_byte(8'h41, a);
    check(a, 8'h01, "own read address ack");
    m.recv_byte(1'b1, b, l);
    check(b, 8'hC3, "first read byte");
    m.recv_byte(1'b0, b, l);
    check(b, 8'h96, "last read byte");
    check(l, 8'h01, "data released on master nack");
    m.stop();
    check(8'(rt_cnt - t0), 8'h02, "bytes taken");
    $display("test read done");
  endtask : t_read

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_por();
    t_good();
    bad_call(32'h07000000, 1, 4'b0000);
    bad_call(32'h0C000000, 1, 4'b0000);
    bad_call(32'h06A40000, 2, 4'b1000);
    bad_call(32'h06A55B00, 3, 4'b1100);
    bad_call(32'h06A55A00, 4, 4'b1110);
    bad_call(32'h06A50000, 2, 4'b1100);
    t_read();
    give_verdict();
  end

  // Whole run needs about 11 us; nine times that means a hang
  initial begin
    #100us;
    fail_count++;
    $display("watchdog expired");
    give_verdict();
  end
endmodule : i2c_slave_soft_reset_tb_top
`default_nettype wire
